// ---- pkg/plc_pkg.sv ----
// Purpose: shared constants and types for the pixel lookup converter
// Assumes: 32-bit AHB-Lite register bus, 12-bit sensor pixels
// Notes: register offsets are byte addresses of aligned words
package plc_pkg;
  localparam int PIX_W = 12;
  localparam int VAL_W = 8;
  localparam int ENTRIES = 1025;
  localparam int ENT_W = 11;
  localparam int IDX_W = 13;
  localparam int FRAC_W = 2;
  localparam int AW = 8;
  localparam logic [IDX_W-1:0] IDX_MAX = 13'h1000;

  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_SELECT = 8'h04;
  localparam logic [AW-1:0] OFS_INDEX = 8'h08;
  localparam logic [AW-1:0] OFS_VALUE = 8'h0C;
  localparam logic [AW-1:0] OFS_FORMAT = 8'h10;
  localparam logic [AW-1:0] OFS_CFGSET = 8'h14;
  localparam logic [AW-1:0] OFS_STATUS = 8'h18;

  localparam logic [1:0] COLOR_RED = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_BLUE = 2'h2;
  localparam int NCOLOR = 3;

  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_10 = 2'h1;
  localparam logic [1:0] FMT_12 = 2'h2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic use_lut;
    logic [1:0] fmt;
    logic [1:0] color;
    logic line_b;
    logic [PIX_W-1:0] data;
  } plc_pix_s;
endpackage

// ---- hdl/plc_lut_color.sv ----
// Purpose: one color table with two-stage read and interpolation
// Assumes: write and pixel read on the same clock
// Notes: table contents are not cleared by reset
`timescale 1ns/1ps
module plc_lut_color
  import plc_pkg::*;
#(
  parameter int ENTRIES_P = ENTRIES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_en_i,
  input wire logic [ENT_W-1:0] wr_ent_i,
  input wire logic [VAL_W-1:0] wr_val_i,
  input wire logic [PIX_W-1:0] pix_i,
  output logic [VAL_W-1:0] map_o
);
  logic [VAL_W-1:0] mem [0:ENTRIES_P-1];
  logic [VAL_W-1:0] lo_q, hi_q, map_q;
  logic [FRAC_W-1:0] frac_q;
  wire logic [ENT_W-1:0] ent_lo = {1'b0, pix_i[PIX_W-1:FRAC_W]};
  wire logic [ENT_W-1:0] ent_hi = ent_lo + 11'h001;
  wire logic signed [VAL_W:0] diff = $signed({1'b0, hi_q}) - $signed({1'b0, lo_q});
  wire logic signed [VAL_W+3:0] prod = diff * $signed({1'b0, frac_q});
  // never negative: lo*4 + (hi-lo)*frac >= lo, so the slice is safe
  wire logic signed [VAL_W+3:0] acc = $signed({2'b00, lo_q, 2'b00}) + prod;

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_ent_i] <= wr_val_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      frac_q <= 2'h0;
      map_q <= 8'h00;
    end else begin
      lo_q <= mem[ent_lo];
      hi_q <= mem[ent_hi];
      frac_q <= pix_i[FRAC_W-1:0];
      map_q <= acc[VAL_W+1:FRAC_W];
    end
  end

  assign map_o = map_q;
endmodule // plc_lut_color

// ---- hdl/plc_top.sv ----
// Purpose: per-color 12-bit to 8-bit pixel mapper with AHB-Lite registers
// Assumes: sensor stream on CLK_I, no back-pressure, zero-wait bus slave
// Notes:
// Overview of operation
// - disabled with 8-bit format, output is sensor value with four low bits dropped
// - three separate tables; each pixel goes through its own color's table
// - enabled with 10/12-bit format, mapped byte on top, low bits zero
// - each table holds 1025 entries for indices 0,4,...,4096
// - input at a defined index outputs that stored entry unchanged
// - other inputs interpolate linearly between the two nearest entries
// - entry 4096 only serves as upper point for inputs 4093..4095
// - one enable switches all three tables together
// - green pixels of line A and line B share the green table
// - factory set passes unwritten colors through; user set uses stored entries
// - software writes select, then index, then value to store an entry
// - mapping applies only while the mode field selects enabled
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module plc_top
  import plc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  input wire logic PIX_VALID_I,
  input wire logic [PIX_W-1:0] PIX_DATA_I,
  input wire logic [1:0] PIX_COLOR_I,
  input wire logic PIX_LINE_B_I,
  output logic VID_VALID_O,
  output logic [PIX_W-1:0] VID_DATA_O,
  output logic [1:0] VID_COLOR_O,
  output logic VID_LINE_B_O
);
  // ---------------- register bus ----------------
  logic enable_q, user_set_q;
  logic [1:0] select_q, format_q;
  logic [IDX_W-1:0] index_q;
  logic [VAL_W-1:0] value_q;
  logic [NCOLOR-1:0] written_q;
  logic wr_pend_q;
  logic [AW-1:0] wr_addr_q;
  logic [31:0] rdata_q;

  wire logic addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire logic wr_take = addr_phase & HWRITE_I;
  wire logic rd_take = addr_phase & ~HWRITE_I;
  wire logic [AW-1:0] rd_addr = HADDR_I[AW-1:0];
  wire logic wr_mode = wr_pend_q & (wr_addr_q == OFS_MODE);
  wire logic wr_select = wr_pend_q & (wr_addr_q == OFS_SELECT);
  wire logic wr_index = wr_pend_q & (wr_addr_q == OFS_INDEX);
  wire logic wr_value = wr_pend_q & (wr_addr_q == OFS_VALUE);
  wire logic wr_format = wr_pend_q & (wr_addr_q == OFS_FORMAT);
  wire logic wr_cfgset = wr_pend_q & (wr_addr_q == OFS_CFGSET);
  // out-of-range index, color code 3 or bad format are dropped silently
  wire logic index_ok = index_q <= IDX_MAX;
  wire logic select_ok = select_q != 2'h3;
  wire logic format_ok = HWDATA_I[1:0] != 2'h3;
  wire logic tbl_write = wr_value & index_ok & select_ok;
  wire logic [ENT_W-1:0] tbl_ent = index_q[IDX_W-1:FRAC_W];

  wire logic [31:0] rd_mux =
    (rd_addr == OFS_MODE) ? {31'h0000_0000, enable_q} :
    (rd_addr == OFS_SELECT) ? {30'h0000_0000, select_q} :
    (rd_addr == OFS_INDEX) ? {19'h0_0000, index_q} :
    (rd_addr == OFS_VALUE) ? {24'h00_0000, value_q} :
    (rd_addr == OFS_FORMAT) ? {30'h0000_0000, format_q} :
    (rd_addr == OFS_CFGSET) ? {31'h0000_0000, user_set_q} :
    (rd_addr == OFS_STATUS) ? {29'h0000_0000, written_q} :
    32'h0000_0000;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= HADDR_I[AW-1:0];
      end
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      enable_q <= 1'b0;
      select_q <= COLOR_RED;
      index_q <= 13'h0000;
      value_q <= 8'h00;
      format_q <= FMT_8;
      user_set_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        enable_q <= HWDATA_I[0];
      end
      if (wr_select) begin
        select_q <= HWDATA_I[1:0];
      end
      if (wr_index) begin
        index_q <= HWDATA_I[IDX_W-1:0];
      end
      if (wr_value) begin
        value_q <= HWDATA_I[VAL_W-1:0];
      end
      if (wr_format & format_ok) begin
        format_q <= HWDATA_I[1:0];
      end
      if (wr_cfgset) begin
        user_set_q <= HWDATA_I[0];
      end
    end
  end

  // per-color record of whether software rewrote the table since reset
  genvar c;
  generate
    for (c = 0; c < NCOLOR; c++) begin : g_written
      always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          written_q[c] <= 1'b0;
        end else if (tbl_write && (select_q == 2'(c))) begin
          written_q[c] <= 1'b1;
        end
      end
    end
  endgenerate

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata_q;

  // ---------------- pixel pipeline ----------------
  // table index follows color only, so both lines' green share one table
  wire logic [1:0] pix_color = PIX_COLOR_I;
  wire logic color_ok = pix_color != 2'h3;
  wire logic color_written = color_ok & written_q[pix_color];
  // factory set bypasses a color until its table is rewritten
  wire logic lut_live = enable_q & color_ok & (user_set_q | color_written);

  plc_pix_s in_s, s1_q, s2_q;
  logic v1_q, v2_q;
  logic [VAL_W-1:0] map_c [NCOLOR];

  assign in_s.use_lut = lut_live;
  assign in_s.fmt = format_q;
  assign in_s.color = pix_color;
  assign in_s.line_b = PIX_LINE_B_I;
  assign in_s.data = PIX_DATA_I;

  generate
    for (c = 0; c < NCOLOR; c++) begin : g_tbl
      plc_lut_color #(
        .ENTRIES_P(ENTRIES)
      ) u_tbl (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .wr_en_i(tbl_write && (select_q == 2'(c))),
        .wr_ent_i(tbl_ent),
        .wr_val_i(value_q_next(c)),
        .pix_i(PIX_DATA_I),
        .map_o(map_c[c])
      );
    end
  endgenerate

  // the value lands in the table in the same data phase it is written
  function automatic logic [VAL_W-1:0] value_q_next(input int unused_c);
    value_q_next = HWDATA_I[VAL_W-1:0];
  endfunction

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      v1_q <= PIX_VALID_I;
      v2_q <= v1_q;
      s1_q <= in_s;
      s2_q <= s1_q;
    end
  end

  // output formatting, stage two
  wire logic [VAL_W-1:0] map_sel = (s2_q.color == COLOR_GREEN) ? map_c[1] :
                                   (s2_q.color == COLOR_BLUE) ? map_c[2] : map_c[0];
  wire logic [PIX_W-1:0] raw_8 = {4'h0, s2_q.data[PIX_W-1:4]};
  wire logic [PIX_W-1:0] raw_10 = {2'h0, s2_q.data[PIX_W-1:2]};
  wire logic [PIX_W-1:0] lut_8 = {4'h0, map_sel};
  wire logic [PIX_W-1:0] lut_10 = {2'h0, map_sel, 2'h0};
  wire logic [PIX_W-1:0] lut_12 = {map_sel, 4'h0};
  wire logic [PIX_W-1:0] raw_out = (s2_q.fmt == FMT_8) ? raw_8 :
                                   (s2_q.fmt == FMT_10) ? raw_10 : s2_q.data;
  wire logic [PIX_W-1:0] lut_out = (s2_q.fmt == FMT_8) ? lut_8 :
                                   (s2_q.fmt == FMT_10) ? lut_10 : lut_12;
  wire logic [PIX_W-1:0] out_data = s2_q.use_lut ? lut_out : raw_out;

  logic vo_q, lb_q;
  logic [PIX_W-1:0] do_q;
  logic [1:0] co_q;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      vo_q <= 1'b0;
      do_q <= 12'h000;
      co_q <= 2'h0;
      lb_q <= 1'b0;
    end else begin
      vo_q <= v2_q;
      do_q <= out_data;
      co_q <= s2_q.color;
      lb_q <= s2_q.line_b;
    end
  end

  assign VID_VALID_O = vo_q;
  assign VID_DATA_O = do_q;
  assign VID_COLOR_O = co_q;
  assign VID_LINE_B_O = lb_q;
endmodule // plc_top

// ---- dv/plc_chk.sv ----
// Purpose: port checks for the pixel lookup converter
// Assumes: one clock, one bus slave
// Notes: mode and format shadowed from bus writes
`timescale 1ns/1ps
module plc_chk
  import plc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic [31:0] HRDATA_O,
  input wire logic PIX_VALID_I,
  input wire logic [PIX_W-1:0] PIX_DATA_I,
  input wire logic [1:0] PIX_COLOR_I,
  input wire logic PIX_LINE_B_I,
  input wire logic VID_VALID_O,
  input wire logic [PIX_W-1:0] VID_DATA_O,
  input wire logic [1:0] VID_COLOR_O,
  input wire logic VID_LINE_B_O
);
  logic wr_q;
  logic [AW-1:0] wa_q;
  logic mode_q;
  logic [1:0] fmt_q;
  logic [1:0] up_q;
  wire rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
  wire wr_take = HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
  wire map_on = PIX_VALID_I & mode_q & (PIX_COLOR_I != 2'h3);
  // shadow updates at the data-phase edge, like the register itself
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {wr_q, wa_q, mode_q, fmt_q} <= '0;
      up_q <= 2'h0;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      wr_q <= wr_take;
      wa_q <= HADDR_I[AW-1:0];
      if (wr_q && wa_q == OFS_MODE) mode_q <= HWDATA_I[0];
      if (wr_q && wa_q == OFS_FORMAT && HWDATA_I[1:0] != 2'h3) fmt_q <= HWDATA_I[1:0];
    end
  end
  default clocking @(posedge CLK_I); endclocking
  // three-deep history still holds pre-reset samples right after release
  default disable iff (!RESETN_I || up_q != 2'h3);
  property p_rdy; HREADYOUT_O && !HRESP_O; endproperty
  a_rdy: assert property (p_rdy) else $error("bus wait or error");
  property p_hrd; !rd_take |=> $stable(HRDATA_O); endproperty
  a_hrd: assert property (p_hrd) else $error("read data moved");
  property p_vv; VID_VALID_O == $past(PIX_VALID_I, 3); endproperty
  a_vv: assert property (p_vv) else $error("video valid latency");
  property p_side; {VID_COLOR_O, VID_LINE_B_O} == $past({PIX_COLOR_I, PIX_LINE_B_I}, 3); endproperty
  a_side: assert property (p_side) else $error("color or line lost");
  property p_raw; PIX_VALID_I && fmt_q == FMT_8 && !map_on |-> ##3 VID_DATA_O == {4'h0, $past(PIX_DATA_I[11:4], 3)};
  endproperty
  a_raw: assert property (p_raw) else $error("raw 8-bit wrong");
  property p_raw10; PIX_VALID_I && !mode_q && fmt_q == FMT_10 |-> ##3 VID_DATA_O == {2'h0, $past(PIX_DATA_I[11:2], 3)};
  endproperty
  a_raw10: assert property (p_raw10) else $error("raw 10-bit wrong");
  property p_p12; map_on && fmt_q == FMT_12 |-> ##3 VID_DATA_O[3:0] == 4'h0; endproperty
  a_p12: assert property (p_p12) else $error("12-bit pad");
  property p_p10; map_on && fmt_q == FMT_10 |-> ##3 VID_DATA_O[1:0] == 2'h0 && VID_DATA_O[11:10] == 2'h0; endproperty
  a_p10: assert property (p_p10) else $error("10-bit pad");
endmodule // plc_chk
bind plc_top plc_chk i_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O), .PIX_VALID_I(PIX_VALID_I), .PIX_DATA_I(PIX_DATA_I),
  .PIX_COLOR_I(PIX_COLOR_I), .PIX_LINE_B_I(PIX_LINE_B_I), .VID_VALID_O(VID_VALID_O), .VID_DATA_O(VID_DATA_O),
  .VID_COLOR_O(VID_COLOR_O), .VID_LINE_B_O(VID_LINE_B_O));

// ---- dv/plc_sensor_mdl.sv ----
// Purpose: sensor pixel source for the converter input
// Assumes: one pixel per send pulse
// Notes: idle data toggles so stale values never look valid
`timescale 1ns/1ps
module plc_sensor_mdl
  import plc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic send_i,
  input wire plc_pix_s pix_i,
  output plc_pix_s pix_o,
  output logic valid_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pix_o <= '0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= send_i;
      if (send_i) pix_o <= pix_i;
      else pix_o.data <= ~pix_o.data;
    end
  end
endmodule // plc_sensor_mdl

// ---- dv/testbench.sv ----
// Purpose: register and pixel checks of the converter
// Assumes: zero-wait slave, sensor model as source
// Notes: expectations from the interpolation formula
`timescale 1ns/1ps
module testbench;
  import plc_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic send = 1'b0;
  plc_pix_s sp = '0;
  plc_pix_s pm;
  logic pv, hready, vv, vl;
  logic [31:0] hrdata;
  logic [11:0] vd;
  logic [1:0] vc;
  int n_mismatch = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  plc_sensor_mdl i_src (.clk_i(clk), .resetn_i(rst_n), .send_i(send), .pix_i(sp), .pix_o(pm), .valid_o(pv));
  plc_top i_dut (.CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRESP_O(), .HRDATA_O(hrdata), .PIX_VALID_I(pv), .PIX_DATA_I(pm.data), .PIX_COLOR_I(pm.color),
    .PIX_LINE_B_I(pm.line_b), .VID_VALID_O(vv), .VID_DATA_O(vd), .VID_COLOR_O(vc), .VID_LINE_B_O(vl));
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] v, input logic [31:0] e);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", s, e, v);
    end
  endtask
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      stop_test;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NONSEQ, 1'b1, 24'h00_0000, a};
    wt;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    {hsel, htrans, hwrite, haddr} <= {1'b1, HTRANS_NONSEQ, 1'b0, 24'h00_0000, a};
    wt;
    htrans <= 2'h0;
    wt;
    chk("rdata", hrdata, e);
  endtask
  task ld(input logic [1:0] c, input logic [12:0] i, input logic [7:0] v);
    wr(OFS_SELECT, c);
    wr(OFS_INDEX, i);
    wr(OFS_VALUE, v);
  endtask
  task pix(input logic [11:0] d, input logic [1:0] c, input logic l, input logic [11:0] e);
    int n;
    send <= 1'b1;
    sp <= {1'b0, 2'h0, c, l, d};
    @(posedge clk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (vv !== 1'b1 && n < 9);
    if (n >= 9) begin
      n_mismatch++;
      stop_test;
    end
    chk("video", vd, e);
    chk("side", {vc, vl}, {c, l});
    @(posedge clk);
  endtask
  // floor of the signed step, so falling tables round down too
  function logic [7:0] ip(input int lo, input int hi, input int r);
    return 8'(lo + (((hi - lo) * r) >>> 2));
  endfunction
  initial begin
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(OFS_MODE, 32'h0000_0000);
    pix(12'hABC, COLOR_RED, 1'b0, 12'h0AB);
    wr(OFS_FORMAT, FMT_10);
    pix(12'hABC, COLOR_RED, 1'b0, 12'h2AF);
    ld(COLOR_RED, 13'h0008, 8'h10);
    ld(COLOR_RED, 13'h000C, 8'h50);
    ld(COLOR_GREEN, 13'h0008, 8'h80);
    ld(COLOR_GREEN, 13'h000C, 8'h00);
    rc(OFS_STATUS, 32'h0000_0003);
    rc(8'h1C, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0001);
    pix(12'h009, COLOR_RED, 1'b0, {2'h0, ip(16, 80, 1), 2'h0});
    wr(OFS_FORMAT, FMT_12);
    pix(12'h009, COLOR_RED, 1'b0, {ip(16, 80, 1), 4'h0});
    wr(OFS_FORMAT, FMT_8);
    pix(12'h008, COLOR_RED, 1'b0, 12'h010);
    pix(12'h00B, COLOR_RED, 1'b0, {4'h0, ip(16, 80, 3)});
    pix(12'h00A, COLOR_GREEN, 1'b0, {4'h0, ip(128, 0, 2)});
    pix(12'h00A, COLOR_GREEN, 1'b1, {4'h0, ip(128, 0, 2)});
    pix(12'hABC, COLOR_BLUE, 1'b1, 12'h0AB);
    pix(12'hABC, 2'h3, 1'b1, 12'h0AB);
    ld(COLOR_BLUE, 13'h0FFC, 8'h04);
    ld(COLOR_BLUE, 13'h1000, 8'hFF);
    pix(12'hFFF, COLOR_BLUE, 1'b1, {4'h0, ip(4, 255, 3)});
    pix(12'hFFC, COLOR_BLUE, 1'b1, 12'h004);
    wr(OFS_CFGSET, 32'h0000_0001);
    pix(12'h009, COLOR_RED, 1'b0, {4'h0, ip(16, 80, 1)});
    wr(OFS_FORMAT, 32'h0000_0003);
    rc(OFS_FORMAT, 32'h0000_0000);
    stop_test;
  end
endmodule // testbench
